// ===== src/ucrb_pkg.sv
`default_nettype none

package ucrb_pkg;

    // serial frame shape
    localparam int         ADDR_W     = 15;
    localparam int         INSTR_W    = 16;
    localparam int         RW_BIT     = 15;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [3:0] DATA_LAST  = 4'h7;

    // fixed offsets; the two part code offsets are not in the table
    localparam logic [14:0] ADDR_CFG     = 15'h0000;
    localparam logic [14:0] ADDR_ID_LOW  = 15'h0004;
    localparam logic [14:0] ADDR_ID_HIGH = 15'h0005;
    localparam logic [14:0] ADDR_BIAS    = 15'h0100;
    localparam logic [14:0] ADDR_ATTEN   = 15'h0300;

    // stored register table, index order
    localparam int NUM_REGS   = 16;
    localparam int IDX_CFG    = 0;
    localparam int IDX_BIAS   = 1;
    localparam int IDX_ATTEN  = 2;

    localparam logic [14:0] REG_ADDR [NUM_REGS] = '{
        ADDR_CFG, ADDR_BIAS, ADDR_ATTEN, 15'h0301,
        15'h0302, 15'h0303, 15'h0304, 15'h0305,
        15'h0306, 15'h0307, 15'h0308, 15'h0309,
        15'h030A, 15'h030C, 15'h030D, 15'h030E};

    localparam logic [7:0] REG_RST [NUM_REGS] = '{
        8'h00, 8'hDF, 8'h00, 8'h00, 8'hCA, 8'h01, 8'hEF, 8'h00,
        8'h0E, 8'h00, 8'h08, 8'h88, 8'h88, 8'h00, 8'h08, 8'h08};

    // writable bits; zero mask marks a read-only register
    localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
        8'hFF, 8'hFF, 8'h1F, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h0E,
        8'h00, 8'h7E, 8'h0F, 8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'h1F};

    // interface configuration fields, mirrored pairs
    localparam int CFG_SRST_HI  = 7;
    localparam int CFG_ORDER_HI = 6;
    localparam int CFG_END_HI   = 5;
    localparam int CFG_SDO_HI   = 4;
    localparam int CFG_SDO_LO   = 3;
    localparam int CFG_END_LO   = 2;
    localparam int CFG_ORDER_LO = 1;
    localparam int CFG_SRST_LO  = 0;

    // stage bias enable fields
    localparam int BIAS_RFC    = 7;
    localparam int BIAS_SYNTH  = 6;
    localparam int BIAS_DET    = 5;
    localparam int BIAS_SWITCH = 4;
    localparam int BIAS_DRV    = 3;
    localparam int BIAS_PRE    = 2;
    localparam int BIAS_LO     = 1;
    localparam int BIAS_IF     = 0;

    // serial engine states
    typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} ucrb_state_t;

endpackage

`default_nettype wire

// ===== src/ucrb_bank.sv
`default_nettype none

module ucrb_bank #(
    parameter logic [7:0] PART_CODE_LOW  = 8'hA5, // arbitrary value
    parameter logic [7:0] PART_CODE_HIGH = 8'h3C  // arbitrary value
) (
    // clock, reset, enable
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    // serial port pins
    input  wire logic sclk_i,
    input  wire logic csb_n_i,
    input  wire logic sdio_i,
    output logic      sdio_o,
    output logic      sdio_oe_o,
    output logic      sdo_o,
    output logic      sdo_oe_o,
    // interface settings in force
    output logic      software_reset_field_o,
    output logic      msb_first_o,
    output logic      big_endian_o,
    output logic      serial_out_enable_o,
    // stage bias enables
    output logic      rf_controller_bias_en_o,
    output logic      synthesizer_bias_en_o,
    output logic      detector_bias_en_o,
    output logic      transmit_output_switch_en_o,
    output logic      output_driver_bias_en_o,
    output logic      pre_driver_bias_en_o,
    output logic      lo_amplifier_bias_en_o,
    output logic      if_amplifier_bias_en_o
);

    // pin synchronisers; stage 2 of sclk is an edge history
    logic [2:0]                  sclk_s;
    logic [1:0]                  csb_s;
    logic [1:0]                  sdi_s;

    // serial engine state
    ucrb_pkg::ucrb_state_t       state;
    logic [3:0]                  bcnt;
    logic [15:0]                 isr;
    logic [7:0]                  dsr;
    logic [14:0]                 addr;
    logic                        rd_flag;
    logic [7:0]                  txb;
    logic                        out_bit;

    // write strobe towards the register file
    logic                        wr_stb;
    logic [14:0]                 wr_addr;
    logic [7:0]                  wr_data;

    // register file and read side
    logic [7:0]                  regs [ucrb_pkg::NUM_REGS];
    logic [7:0]                  rd_data;

    // decoded helpers
    wire logic                   sclk_rise;
    wire logic                   sclk_fall;
    wire logic                   csb_act;
    wire logic                   soft_rst;
    wire logic                   msb_first;
    wire logic                   big_endian;
    wire logic                   sdo_en;
    wire logic                   rd_active;
    wire logic [15:0]            isr_sh;
    wire logic [7:0]             dsr_sh;
    wire logic [14:0]            addr_step;
    wire logic [7:0]             tx_src;
    wire logic [2:0]             out_idx;

    // table lookup shared by the write and read paths
    function automatic logic addr_hit(
        input logic [14:0] a,
        input int          k
    );
        return a == ucrb_pkg::REG_ADDR[k];
    endfunction

    // three flops on sclk so edges come from settled samples only
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            sclk_s <= 3'h0;
            csb_s  <= 2'h3;
            sdi_s  <= 2'h0;
        end
        else if (ce_i)
        begin
            sclk_s <= {sclk_s[1:0], sclk_i};
            csb_s  <= {csb_s[0], csb_n_i};
            sdi_s  <= {sdi_s[0], sdio_i};
        end
    end

    // edges and frame level from second stage onward
    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];
    assign csb_act   = ~csb_s[1];

    assign soft_rst   = regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_SRST_HI]
                      | regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_SRST_LO];
    assign msb_first  = regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_ORDER_HI]
                      | regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_ORDER_LO];
    assign big_endian = regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_END_HI]
                      | regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_END_LO];
    assign sdo_en     = regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_SDO_HI]
                      | regs[ucrb_pkg::IDX_CFG][ucrb_pkg::CFG_SDO_LO];

    assign isr_sh = msb_first ? {isr[14:0], sdi_s[1]} : {sdi_s[1], isr[15:1]};
    assign dsr_sh = msb_first ? {dsr[6:0], sdi_s[1]} : {sdi_s[1], dsr[7:1]};
    assign addr_step = big_endian ? 15'(addr - 15'h0001)
                                  : 15'(addr + 15'h0001);
    // serial engine: instruction word, then data bytes streamed
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state   <= ucrb_pkg::ST_IDLE;
            bcnt    <= 4'h0;
            isr     <= 16'h0000;
            dsr     <= 8'h00;
            addr    <= 15'h0000;
            rd_flag <= 1'b0;
            wr_stb  <= 1'b0;
            wr_addr <= 15'h0000;
            wr_data <= 8'h00;
        end
        else if (ce_i)
        begin
            wr_stb <= 1'b0;
            if (!csb_act)
            begin
                state <= ucrb_pkg::ST_IDLE;
                bcnt  <= 4'h0;
            end
            else
            begin
                case (state)
                    ucrb_pkg::ST_IDLE:
                    begin
                        state <= ucrb_pkg::ST_INSTR;
                        bcnt  <= 4'h0;
                    end
                    ucrb_pkg::ST_INSTR:
                    begin
                        if (sclk_rise)
                        begin
                            isr  <= isr_sh;
                            bcnt <= 4'(bcnt + 4'h1);
                            if (bcnt == ucrb_pkg::INSTR_LAST)
                            begin
                                state   <= ucrb_pkg::ST_DATA;
                                bcnt    <= 4'h0;
                                rd_flag <= isr_sh[ucrb_pkg::RW_BIT];
                                addr    <= isr_sh[14:0];
                            end
                        end
                    end
                    ucrb_pkg::ST_DATA:
                    begin
                        if (sclk_rise)
                        begin
                            dsr  <= dsr_sh;
                            bcnt <= 4'(bcnt + 4'h1);
                            if (bcnt == ucrb_pkg::DATA_LAST)
                            begin
                                bcnt <= 4'h0;
                                addr <= addr_step;
                                if (!rd_flag)
                                begin
                                    wr_stb  <= 1'b1;
                                    wr_addr <= addr;
                                    wr_data <= dsr_sh;
                                end
                            end
                        end
                    end
                    default:
                    begin
                        state <= ucrb_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // register file; soft reset clears itself since cfg resets to zero
    generate
        for (genvar i = 0; i < ucrb_pkg::NUM_REGS; i++)
        begin : g_reg
            logic [7:0] q;
            wire logic  hit;
            wire logic [7:0] wm;
            assign hit = wr_stb & addr_hit(wr_addr, i);
            // mask keeps reserved and read-only bits
            assign wm  = ucrb_pkg::REG_WMASK[i];
            always_ff @(posedge mclk_i)
            begin
                if (reset_i)
                begin
                    q <= ucrb_pkg::REG_RST[i];
                end
                else if (ce_i)
                begin
                    if (soft_rst)
                    begin
                        q <= ucrb_pkg::REG_RST[i];
                    end
                    else if (hit)
                    begin
                        q <= (q & ~wm) | (wr_data & wm);
                    end
                end
            end

            assign regs[i] = q;
        end
    endgenerate

    // read select; unmapped offsets return zero
    always_comb
    begin
        rd_data = 8'h00;
        for (int k = 0; k < ucrb_pkg::NUM_REGS; k++)
        begin
            if (addr_hit(addr, k))
            begin
                rd_data = regs[k];
            end
        end
        if (addr == ucrb_pkg::ADDR_ID_LOW)
        begin
            rd_data = PART_CODE_LOW;
        end
        if (addr == ucrb_pkg::ADDR_ID_HIGH)
        begin
            rd_data = PART_CODE_HIGH;
        end
    end

    // byte loads at its first falling edge, after addr settled
    assign tx_src  = (bcnt == 4'h0) ? rd_data : txb;
    assign out_idx = msb_first ? ~bcnt[2:0] : bcnt[2:0];

    // read data changes on falling sclk, host samples on rising
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            txb     <= 8'h00;
            out_bit <= 1'b0;
        end
        else if (ce_i)
        begin
            if (sclk_fall && state == ucrb_pkg::ST_DATA && rd_flag)
            begin
                txb     <= tx_src;
                out_bit <= tx_src[out_idx];
            end
        end
    end

    // output enable picks four-wire or three-wire readback
    assign rd_active = (state == ucrb_pkg::ST_DATA) & rd_flag & csb_act;
    assign sdo_o     = out_bit;
    assign sdio_o    = out_bit;
    assign sdo_oe_o  = rd_active & sdo_en;
    assign sdio_oe_o = rd_active & ~sdo_en;

    // settings in force
    assign software_reset_field_o = soft_rst;
    assign msb_first_o            = msb_first;
    assign big_endian_o           = big_endian;
    assign serial_out_enable_o    = sdo_en;

    assign rf_controller_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_RFC];
    assign synthesizer_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_SYNTH];
    assign detector_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_DET];
    assign transmit_output_switch_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_SWITCH];
    assign output_driver_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_DRV];
    assign pre_driver_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_PRE];
    assign lo_amplifier_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_LO];
    assign if_amplifier_bias_en_o = regs[ucrb_pkg::IDX_BIAS][ucrb_pkg::BIAS_IF];

    // checks, all in the one clock domain
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    wire logic cfg_wr  = wr_stb & (wr_addr == ucrb_pkg::ADDR_CFG);
    wire logic bias_wr = wr_stb & (wr_addr == ucrb_pkg::ADDR_BIAS);
    wire logic [7:0] bias_vec = {rf_controller_bias_en_o, synthesizer_bias_en_o,
        detector_bias_en_o, transmit_output_switch_en_o, output_driver_bias_en_o,
        pre_driver_bias_en_o, lo_amplifier_bias_en_o, if_amplifier_bias_en_o};
    AST_SRST_DEFAULTS: assert property (
        ce_i && soft_rst |=> !software_reset_field_o && bias_vec == 8'hDF)
        else $error("soft reset did not restore defaults");
    AST_CFG_WRITE: assert property (
        ce_i && cfg_wr && !soft_rst && !wr_data[7] && !wr_data[0]
        |=> regs[ucrb_pkg::IDX_CFG] == $past(wr_data))
        else $error("config write not stored");
    AST_ID_LOW: assert property (
        ce_i && sclk_fall && rd_active && bcnt == 4'h0
        && addr == ucrb_pkg::ADDR_ID_LOW |=> txb == PART_CODE_LOW)
        else $error("low part code not returned");
    AST_ID_HIGH: assert property (
        ce_i && sclk_fall && rd_active && bcnt == 4'h0
        && addr == ucrb_pkg::ADDR_ID_HIGH |=> txb == PART_CODE_HIGH)
        else $error("high part code not returned");
    AST_BIAS_WRITE: assert property (
        ce_i && bias_wr && !soft_rst |=> bias_vec == $past(wr_data))
        else $error("bias write not reflected on enables");
    AST_DET_OFF: assert property (
        ce_i && soft_rst |=> !detector_bias_en_o && rf_controller_bias_en_o
        && if_amplifier_bias_en_o)
        else $error("detector bias default wrong");
    AST_RESERVED: assert property (
        ce_i && wr_stb && wr_addr == ucrb_pkg::ADDR_ATTEN && !soft_rst
        |=> regs[ucrb_pkg::IDX_ATTEN][7:5] == 3'h0)
        else $error("reserved bits took a write");
    AST_WRITE_STROBE: assert property (
        ce_i && state == ucrb_pkg::ST_DATA && sclk_rise && csb_act
        && bcnt == ucrb_pkg::DATA_LAST && !rd_flag |=> wr_stb ##1 !wr_stb)
        else $error("write strobe not one cycle after last bit");
    AST_OE_SPLIT: assert property (
        rd_active |-> (sdo_oe_o == sdo_en) && (sdio_oe_o == !sdo_en))
        else $error("readback pin choice wrong");

    COV_WRITE: cover property (ce_i && bias_wr);
    COV_READ_ID: cover property (rd_active && addr == ucrb_pkg::ADDR_ID_LOW);
    COV_SRST: cover property (ce_i && soft_rst);
    COV_THREE_WIRE: cover property (sdio_oe_o ##1 sclk_fall);
endmodule

`default_nettype wire

// ===== src/ucrb_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

// ===== testbench/ucrb_spi_host.sv
`default_nettype none

module ucrb_spi_host (
    // system clock
    input  wire logic mclk_i,
    // resolved pin levels
    input  wire logic sdio_wire_i,
    input  wire logic sdo_wire_i,
    // host pin drivers
    output var logic  sclk_o,
    output var logic  csb_n_o,
    output var logic  sdio_drv_o,
    output var logic  sdio_drv_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // 6 mclk per half period, margin over the 3 mclk minimum and read latency
    localparam int HALF = 6;

    // idle: clock parked low, deselected, data released
    initial
    begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        sdio_drv_o = 1'b0;
        sdio_drv_oe_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // data set while sclk low, sampled by both sides on the rise
    task automatic clock_bit(input logic drive, input logic bit_v, input logic four_wire,
                             output logic got);
        sdio_drv_oe_o <= drive;
        sdio_drv_o <= bit_v;
        wait_clk(HALF);
        sclk_o <= 1'b1;
        got = four_wire ? sdo_wire_i : sdio_wire_i;
        wait_clk(HALF);
        sclk_o <= 1'b0;
    endtask

    // one frame: 16 instruction bits then nbytes data bytes, byte k in bits 8k+7:8k
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [15:0] wdata,
                        input int nbytes, input logic msb, input logic four_wire,
                        output logic [15:0] rdata);
        logic [15:0] instr;
        logic        got;
        instr = {rd, addr};
        rdata = 16'h0000;
        @(posedge mclk_i);
        csb_n_o <= 1'b0;
        wait_clk(3);
        for (int i = 0; i < 16; i++)
            clock_bit(1'b1, instr[msb ? 15 - i : i], four_wire, got);
        // host lets go of the data line for every read byte
        for (int k = 0; k < nbytes; k++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                clock_bit(!rd, wdata[8 * k + (msb ? 7 - i : i)], four_wire, got);
                rdata[8 * k + (msb ? 7 - i : i)] = got;
            end
        end
        wait_clk(HALF);
        csb_n_o <= 1'b1;
        sdio_drv_oe_o <= 1'b0;
        wait_clk(HALF);
    endtask
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // arbitrary part code values
    localparam logic [7:0] CODE_LO = 8'h5A;
    localparam logic [7:0] CODE_HI = 8'hC3;

    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       toggle = 1'b0;
    logic       sclk, csb_n, host_sdio, host_oe;
    logic       dut_sdio, dut_sdio_oe, dut_sdo, dut_sdo_oe;
    logic       ce = 1'b1;
    wire logic [7:0] bias_vec;
    wire logic [3:0] cfg_bits;
    logic       msb_mode = 1'b0;
    logic       four_mode = 1'b0;
    int         failures = 0;
    int         checked = 0;
    wire logic  sdio_wire;
    wire logic  sdo_wire;

    always #5 mclk = ~mclk;

    // released lines change every cycle so a stale level never passes
    always @(posedge mclk) toggle <= ~toggle;
    assign sdio_wire = dut_sdio_oe ? dut_sdio : (host_oe ? host_sdio : toggle);
    assign sdo_wire = dut_sdo_oe ? dut_sdo : ~toggle;

    ucrb_bank #(.PART_CODE_LOW(CODE_LO), .PART_CODE_HIGH(CODE_HI)) dut_u (
        .mclk_i(mclk), .reset_i(reset), .ce_i(ce),
        .sclk_i(sclk), .csb_n_i(csb_n), .sdio_i(sdio_wire),
        .sdio_o(dut_sdio), .sdio_oe_o(dut_sdio_oe), .sdo_o(dut_sdo), .sdo_oe_o(dut_sdo_oe),
        .software_reset_field_o(cfg_bits[3]), .msb_first_o(cfg_bits[2]),
        .big_endian_o(cfg_bits[1]), .serial_out_enable_o(cfg_bits[0]),
        .rf_controller_bias_en_o(bias_vec[7]), .synthesizer_bias_en_o(bias_vec[6]),
        .detector_bias_en_o(bias_vec[5]), .transmit_output_switch_en_o(bias_vec[4]),
        .output_driver_bias_en_o(bias_vec[3]), .pre_driver_bias_en_o(bias_vec[2]),
        .lo_amplifier_bias_en_o(bias_vec[1]), .if_amplifier_bias_en_o(bias_vec[0]));

    ucrb_spi_host host_u (
        .mclk_i(mclk), .sdio_wire_i(sdio_wire), .sdo_wire_i(sdo_wire),
        .sclk_o(sclk), .csb_n_o(csb_n), .sdio_drv_o(host_sdio), .sdio_drv_oe_o(host_oe));

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [15:0] unused;
        host_u.xfer(1'b0, a, {8'h00, d}, 1, msb_mode, four_mode, unused);
    endtask

    task automatic rd_check(input logic [14:0] a, input logic [7:0] exp);
        logic [15:0] d;
        host_u.xfer(1'b1, a, 16'h0000, 1, msb_mode, four_mode, d);
        check_byte(d[7:0], exp);
    endtask

    // defaults after power-on reset
    task automatic test_reset_values;
        check_byte({4'h0, cfg_bits}, 8'h00);
        check_byte(bias_vec, 8'hDF);
        rd_check(ucrb_pkg::ADDR_BIAS, 8'hDF);
        rd_check(ucrb_pkg::ADDR_CFG, 8'h00);
    endtask

    // part code bytes survive write attempts
    task automatic test_part_code;
        rd_check(ucrb_pkg::ADDR_ID_LOW, CODE_LO);
        wr(ucrb_pkg::ADDR_ID_LOW, ~CODE_LO);
        rd_check(ucrb_pkg::ADDR_ID_LOW, CODE_LO);
        rd_check(ucrb_pkg::ADDR_ID_HIGH, CODE_HI);
        wr(ucrb_pkg::ADDR_ID_HIGH, ~CODE_HI);
        rd_check(ucrb_pkg::ADDR_ID_HIGH, CODE_HI);
    endtask

    // one stage off at a time, so a swapped pin shows up
    task automatic test_bias_bits;
        logic [7:0] v;
        for (int k = 0; k < 8; k++)
        begin
            v = ~(8'h01 << k);
            wr(ucrb_pkg::ADDR_BIAS, v);
            check_byte(bias_vec, v);
            rd_check(ucrb_pkg::ADDR_BIAS, v);
        end
        wr(ucrb_pkg::ADDR_BIAS, 8'hFF);
        check_byte(bias_vec, 8'hFF);
    endtask

    // reserved bits and unmapped places
    task automatic test_reserved;
        wr(ucrb_pkg::ADDR_ATTEN, 8'hFF);
        rd_check(ucrb_pkg::ADDR_ATTEN, 8'h1F);
        wr(15'h0200, 8'h55);
        rd_check(15'h0200, 8'h00);
    endtask

    // each order mirror bit on its own, endian and output mirror bits in pairs, then 4-wire readback
    task automatic test_config;
        wr(ucrb_pkg::ADDR_CFG, 8'h02);
        msb_mode = 1'b1;
        check_byte({4'h0, cfg_bits}, 8'h04);
        wr(ucrb_pkg::ADDR_CFG, 8'h40);
        check_byte({4'h0, cfg_bits}, 8'h04);
        rd_check(ucrb_pkg::ADDR_CFG, 8'h40);
        wr(ucrb_pkg::ADDR_CFG, 8'h14);
        msb_mode = 1'b0;
        four_mode = 1'b1;
        check_byte({4'h0, cfg_bits}, 8'h03);
        rd_check(ucrb_pkg::ADDR_CFG, 8'h14);
        wr(ucrb_pkg::ADDR_CFG, 8'h28);
        check_byte({4'h0, cfg_bits}, 8'h03);
        rd_check(ucrb_pkg::ADDR_BIAS, 8'hFF);
        wr(ucrb_pkg::ADDR_CFG, 8'h00);
        four_mode = 1'b0;
        check_byte({4'h0, cfg_bits}, 8'h00);
    endtask

    // soft reset from either mirror bit restores every default
    task automatic test_soft_reset;
        logic [7:0] v;
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0) ? 8'h01 : 8'h80;
            wr(ucrb_pkg::ADDR_BIAS, 8'h00);
            wr(ucrb_pkg::ADDR_ATTEN, 8'h0A);
            wr(ucrb_pkg::ADDR_CFG, v);
            check_byte(bias_vec, 8'hDF);
            check_byte({4'h0, cfg_bits}, 8'h00);
            rd_check(ucrb_pkg::ADDR_ATTEN, 8'h00);
        end
    endtask

    // second pin reset in mid-run
    task automatic test_hw_reset;
        wr(ucrb_pkg::ADDR_BIAS, 8'h21);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        check_byte(bias_vec, 8'hDF);
    endtask

    // two bytes per frame; address steps up, or down once big endian
    task automatic test_stream;
        logic [15:0] d;
        host_u.xfer(1'b0, 15'h030D, 16'h0A15, 2, msb_mode, four_mode, d);
        rd_check(15'h030D, 8'h15);
        rd_check(15'h030E, 8'h0A);
        wr(ucrb_pkg::ADDR_CFG, 8'h04);
        host_u.xfer(1'b0, 15'h030E, 16'h0613, 2, msb_mode, four_mode, d);
        host_u.xfer(1'b1, 15'h030E, 16'h0000, 2, msb_mode, four_mode, d);
        check_byte(d[7:0], 8'h13);
        check_byte(d[15:8], 8'h06);
        wr(ucrb_pkg::ADDR_CFG, 8'h00);
        check_byte({4'h0, cfg_bits}, 8'h00);
    endtask

    // enable low freezes the bank, so a whole write frame is lost
    task automatic test_clock_enable;
        ce <= 1'b0;
        wr(ucrb_pkg::ADDR_BIAS, 8'h00);
        check_byte(bias_vec, 8'hDF);
        ce <= 1'b1;
        rd_check(ucrb_pkg::ADDR_BIAS, 8'hDF);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence, about 17k cycles of traffic
    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        test_reset_values();
        test_part_code();
        test_bias_bits();
        test_reserved();
        test_config();
        test_stream();
        test_soft_reset();
        test_hw_reset();
        test_clock_enable();
        tally_and_finish();
    end

    // watchdog well beyond the expected run
    initial
    begin
        repeat (40000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
